/* File: hw/dpdc_defines.vh */
`ifndef DPDC_DEFINES_VH
`define DPDC_DEFINES_VH

// register byte offsets
`define DPDC_OFF_CTRL 12'h000
`define DPDC_OFF_PRE0 12'h004
`define DPDC_OFF_CNT0 12'h008
`define DPDC_OFF_PRE1 12'h00c
`define DPDC_OFF_CNT1 12'h010
`define DPDC_OFF_STAT 12'h014
`define DPDC_OFF_MASK 12'h018
`define DPDC_OFF_CMD 12'h01c

// ctrl fields
`define DPDC_CTRL_MOD0 0
`define DPDC_CTRL_MOD1 1
`define DPDC_CTRL_EXT1 2
`define DPDC_CTRL_ROLE_LO 3
`define DPDC_CTRL_ROLE_HI 4

// command bits (write-only pulses)
`define DPDC_CMD_LOAD0 0
`define DPDC_CMD_RUN0 1
`define DPDC_CMD_STOP0 2
`define DPDC_CMD_LOAD1 3
`define DPDC_CMD_RUN1 4
`define DPDC_CMD_STOP1 5

// external pin roles
`define DPDC_ROLE_CLK 2'h0
`define DPDC_ROLE_RTRIG 2'h1
`define DPDC_ROLE_NTRIG 2'h2
`define DPDC_ROLE_GATE 2'h3

// internal clock divide for the internal tick of both timers
`define DPDC_INT_DIV 2'h3

// reset values
`define DPDC_RST_CTRL 8'h00
`define DPDC_RST_PRE 6'h00
`define DPDC_RST_CNT 8'h00
`define DPDC_RST_STAT 2'h0
`define DPDC_RST_MASK 2'h0

`endif

/* File: hw/dpdc_chan.v */
`timescale 1ns/10ps
`include "dpdc_defines.vh"

// one prescaler plus down counter
module dpdc_chan (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // configuration
  input wire [5:0] pre_init,
  input wire [7:0] cnt_init,
  input wire modulo,
  // control
  input wire load,
  input wire run,
  input wire stop,
  input wire tick,
  // status
  output reg [7:0] cnt_q,
  output reg running_q,
  output reg eoc_q
);

  reg [5:0] pre_q;
  wire pre_end;
  wire cnt_end;

  // a zero wraps to 63 first, so it divides by 64
  assign pre_end = (pre_q == 6'h01);
  assign cnt_end = (cnt_q == 8'h01);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 6'h00;
      cnt_q <= 8'h00;
      running_q <= 1'b0;
      eoc_q <= 1'b0;
    end else begin
      eoc_q <= 1'b0;
      if (load) begin
        pre_q <= pre_init;
        cnt_q <= cnt_init;
        running_q <= 1'b1;
      end else if (stop) begin
        running_q <= 1'b0;
      end else begin
        if (run) begin
          running_q <= 1'b1;
        end
        if (running_q && tick) begin
          if (pre_end) begin
            pre_q <= pre_init;
            if (cnt_end) begin
              eoc_q <= 1'b1;
              if (modulo) begin
                cnt_q <= cnt_init;
              end else begin
                cnt_q <= 8'h00;
                running_q <= 1'b0;
              end
            end else begin
              cnt_q <= cnt_q - 8'h01;
            end
          end else begin
            pre_q <= pre_q - 6'h01;
          end
        end
      end
    end
  end

endmodule // dpdc_chan

/* File: hw/dpdc_top.v */
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "dpdc_defines.vh"

// Operation
// - two 8-bit timers, own 6-bit prescalers
// - second timer internal or external, first internal
// - prescaler divides by 1 to 64
// - counter decrements loaded value, 1 to 256
// - end of count raises own interrupt
// - start, stop, resume, restart commands
// - single-pass halts at zero
// - modulo-N reloads and continues
// - counters readable, prescalers not
// - internal source is clock divided by four
// - pin role: clock, triggers, or gate
module dpdc_top (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // pin
  input wire external_timer_pin,
  // interrupts
  output reg first_timer_interrupt,
  output reg second_timer_interrupt,
  output reg irq
);

  // non-retrigger arming states
  localparam ARM_READY = 2'h1;
  localparam ARM_SPENT = 2'h2;

  reg [7:0] ctrl_q;
  reg [5:0] pre0_q;
  reg [7:0] init0_q;
  reg [5:0] pre1_q;
  reg [7:0] init1_q;
  reg [1:0] stat_q;
  reg [1:0] mask_q;
  reg [1:0] div_q;
  reg pin_q;
  reg [1:0] arm_q;
  reg [1:0] arm_d;
  wire trig_armed;
  reg [5:0] cmd_q;
  wire [7:0] cnt0;
  wire [7:0] cnt1;
  wire [1:0] running;
  wire [1:0] eoc;
  wire wr;
  wire rd;
  wire [1:0] role;
  wire int_tick;
  wire pin_rise;
  wire sel_ctrl;
  wire sel_pre0;
  wire sel_cnt0;
  wire sel_pre1;
  wire sel_cnt1;
  wire sel_stat;
  wire sel_mask;
  wire sel_cmd;
  wire wr_ctrl;
  wire wr_pre0;
  wire wr_cnt0;
  wire wr_pre1;
  wire wr_cnt1;
  wire wr_stat;
  wire wr_mask;
  wire wr_cmd;
  reg tick1;
  reg trig_load;
  reg [31:0] rdata_d;
  reg hit;

  function is_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      is_addr = (a[11:2] == off[11:2]);
    end
  endfunction

  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && !penable && !pwrite;
  assign role = ctrl_q[`DPDC_CTRL_ROLE_HI:`DPDC_CTRL_ROLE_LO];
  assign int_tick = (div_q == `DPDC_INT_DIV);
  assign pin_rise = external_timer_pin && !pin_q;
  assign trig_armed = (arm_q == ARM_READY);

  // one address decode shared by writes and reads
  assign sel_ctrl = is_addr(paddr, `DPDC_OFF_CTRL);
  assign sel_pre0 = is_addr(paddr, `DPDC_OFF_PRE0);
  assign sel_cnt0 = is_addr(paddr, `DPDC_OFF_CNT0);
  assign sel_pre1 = is_addr(paddr, `DPDC_OFF_PRE1);
  assign sel_cnt1 = is_addr(paddr, `DPDC_OFF_CNT1);
  assign sel_stat = is_addr(paddr, `DPDC_OFF_STAT);
  assign sel_mask = is_addr(paddr, `DPDC_OFF_MASK);
  assign sel_cmd = is_addr(paddr, `DPDC_OFF_CMD);
  assign wr_ctrl = wr && sel_ctrl;
  assign wr_pre0 = wr && sel_pre0;
  assign wr_cnt0 = wr && sel_cnt0;
  assign wr_pre1 = wr && sel_pre1;
  assign wr_cnt1 = wr && sel_cnt1;
  assign wr_stat = wr && sel_stat;
  assign wr_mask = wr && sel_mask;
  assign wr_cmd = wr && sel_cmd;

  // divide-by-four strobe for the internal tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // previous pin level for edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= external_timer_pin;
    end
  end

  // second timer tick source and trigger handling
  always @* begin
    tick1 = 1'b0;
    trig_load = 1'b0;
    if (!ctrl_q[`DPDC_CTRL_EXT1]) begin
      tick1 = int_tick;
    end else begin
      case (role)
        `DPDC_ROLE_CLK: tick1 = pin_rise;
        `DPDC_ROLE_GATE: tick1 = int_tick && external_timer_pin;
        `DPDC_ROLE_RTRIG: begin
          tick1 = int_tick;
          trig_load = pin_rise;
        end
        `DPDC_ROLE_NTRIG: begin
          tick1 = int_tick;
          trig_load = pin_rise && !running[1] && trig_armed;
        end
        default: tick1 = 1'b0;
      endcase
    end
  end

  // first timer: internal clock only
  dpdc_chan u_ch0 (
    .pclk(pclk),
    .presetn(presetn),
    .pre_init(pre0_q),
    .cnt_init(init0_q),
    .modulo(ctrl_q[`DPDC_CTRL_MOD0]),
    .load(cmd_q[`DPDC_CMD_LOAD0]),
    .run(cmd_q[`DPDC_CMD_RUN0]),
    .stop(cmd_q[`DPDC_CMD_STOP0]),
    .tick(int_tick),
    .cnt_q(cnt0),
    .running_q(running[0]),
    .eoc_q(eoc[0])
  );

  dpdc_chan u_ch1 (
    .pclk(pclk),
    .presetn(presetn),
    .pre_init(pre1_q),
    .cnt_init(init1_q),
    .modulo(ctrl_q[`DPDC_CTRL_MOD1]),
    .load(cmd_q[`DPDC_CMD_LOAD1] | trig_load),
    .run(cmd_q[`DPDC_CMD_RUN1]),
    .stop(cmd_q[`DPDC_CMD_STOP1]),
    .tick(tick1),
    .cnt_q(cnt1),
    .running_q(running[1]),
    .eoc_q(eoc[1])
  );

  // control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `DPDC_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[7:0];
    end
  end

  // first prescaler reload value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre0_q <= `DPDC_RST_PRE;
    end else if (wr_pre0) begin
      pre0_q <= pwdata[5:0];
    end
  end

  // first counter initial value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init0_q <= `DPDC_RST_CNT;
    end else if (wr_cnt0) begin
      init0_q <= pwdata[7:0];
    end
  end

  // second prescaler reload value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre1_q <= `DPDC_RST_PRE;
    end else if (wr_pre1) begin
      pre1_q <= pwdata[5:0];
    end
  end

  // second counter initial value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init1_q <= `DPDC_RST_CNT;
    end else if (wr_cnt1) begin
      init1_q <= pwdata[7:0];
    end
  end

  // interrupt mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= `DPDC_RST_MASK;
    end else if (wr_mask) begin
      mask_q <= pwdata[1:0];
    end
  end

  // command pulses, live for one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 6'h00;
    end else if (wr_cmd) begin
      cmd_q <= pwdata[5:0];
    end else begin
      cmd_q <= 6'h00;
    end
  end

  // status: set wins over write-one-to-clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= `DPDC_RST_STAT;
    end else if (wr_stat) begin
      stat_q <= (stat_q & ~pwdata[1:0]) | eoc;
    end else begin
      stat_q <= stat_q | eoc;
    end
  end

  // non-retrigger arming: spent by a trigger, rearmed by a restart command
  always @* begin
    arm_d = arm_q;
    case (arm_q)
      ARM_READY: begin
        if (trig_load && role == `DPDC_ROLE_NTRIG) arm_d = ARM_SPENT;
      end
      ARM_SPENT: begin
        if (wr_cmd && pwdata[`DPDC_CMD_LOAD1]) arm_d = ARM_READY;
      end
      default: arm_d = ARM_READY;
    endcase
  end

  // arming state register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q <= ARM_READY;
    end else begin
      arm_q <= arm_d;
    end
  end

  // read mux
  always @* begin
    rdata_d = 32'h0000_0000;
    hit = 1'b1;
    if (sel_ctrl) rdata_d = {24'h00_0000, ctrl_q};
    else if (sel_pre0) rdata_d = 32'h0000_0000;
    else if (sel_cnt0) rdata_d = {24'h00_0000, cnt0};
    else if (sel_pre1) rdata_d = 32'h0000_0000;
    else if (sel_cnt1) rdata_d = {24'h00_0000, cnt1};
    else if (sel_stat) rdata_d = {28'h000_0000, running, stat_q};
    else if (sel_mask) rdata_d = {30'h0000_0000, mask_q};
    else if (sel_cmd) rdata_d = 32'h0000_0000;
    else hit = 1'b0;
  end

  // apb answer: one wait-free access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end

  // read data taken in the setup cycle, held until the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      prdata <= rdata_d;
    end
  end

  // per-timer interrupt lines, one cycle behind status
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_timer_interrupt <= 1'b0;
      second_timer_interrupt <= 1'b0;
    end else begin
      first_timer_interrupt <= stat_q[0] && mask_q[0];
      second_timer_interrupt <= stat_q[1] && mask_q[1];
    end
  end

  // summary interrupt, same timing as the per-timer lines
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

endmodule // dpdc_top

/* File: bench/dpdc_asserts.sv */
`timescale 1ns/10ps
module dpdc_asserts (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // interrupts
  input wire first_timer_interrupt,
  input wire second_timer_interrupt,
  input wire irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_idle_quiet: assert property (!psel |=> !pready)
    else $error("ready while idle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read data");
  a_irq_or: assert property (irq == (first_timer_interrupt || second_timer_interrupt))
    else $error("irq not or");
  a_irq_sticky: assert property (irq && !psel && !$past(psel) |=> irq)
    else $error("irq dropped");
  c_first: cover property (first_timer_interrupt);
  c_second: cover property (second_timer_interrupt);
  c_refused: cover property (pslverr);
endmodule // dpdc_asserts

bind dpdc_top dpdc_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .first_timer_interrupt, .second_timer_interrupt, .irq);

/* File: bench/dpdc_pin_model.sv */
`timescale 1ns/10ps
// outside world on the timer pin; low between bursts
module dpdc_pin_model (
  // clock
  input wire pclk,
  // pin
  output reg pin
);
  initial pin = 1'b0;
  // n rising edges, each high for hi cycles
  task pulse(input int n, input int hi);
    repeat (n) begin
      @(posedge pclk);
      pin <= 1'b1;
      repeat (hi) @(posedge pclk);
      pin <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
endmodule // dpdc_pin_model

/* File: bench/dual_prescaled_down_counter_tb.sv */
`timescale 1ns/10ps
`include "dpdc_defines.vh"
module dual_prescaled_down_counter_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rs;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, v;
  wire [31:0] prdata;
  wire pready, pslverr, pin, i0, i1, irq;
  int err_total = 0, num_checks = 0;
  always #4 pclk = ~pclk;
  dpdc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_timer_pin(pin), .first_timer_interrupt(i0),
    .second_timer_interrupt(i1), .irq(irq));
  dpdc_pin_model pm (.pclk(pclk), .pin(pin));
  task stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    rs = pslverr;
    if (n >= 20) err_total++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  // poll status until every bit of m shows, then judge it
  task poll(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      xfer(1'b0, `DPDC_OFF_STAT, 32'h0000_0000);
      n++;
    end while ((rd & m) != m && n < 200);
    chk(rd & m, m);
  endtask
  task t_reg;
    rdc(`DPDC_OFF_CTRL, 32'h0000_0000);
    rdc(`DPDC_OFF_MASK, 32'h0000_0000);
    wr(12'h020, 32'h0000_00ff);
    chk(32'(rs), 32'h0000_0001);
    rdc(12'h020, 32'h0000_0000);
  endtask
  task t_single;
    wr(`DPDC_OFF_PRE0, 32'h0000_0001);
    wr(`DPDC_OFF_CNT0, 32'h0000_0002);
    wr(`DPDC_OFF_CMD, 32'h0000_0001);
    poll(32'h0000_0001);
    wr(`DPDC_OFF_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(32'({i0, i1, irq}), 32'h0000_0005);
    wr(`DPDC_OFF_MASK, 32'h0000_0000);
    rdc(`DPDC_OFF_CNT0, 32'h0000_0000);
    rdc(`DPDC_OFF_PRE0, 32'h0000_0000);
    wr(`DPDC_OFF_STAT, 32'h0000_0001);
    rdc(`DPDC_OFF_STAT, 32'h0000_0000);
  endtask
  // prescaler zero divides by 64, count zero runs 256 steps
  task t_long;
    wr(`DPDC_OFF_PRE0, 32'h0000_0000);
    wr(`DPDC_OFF_CNT0, 32'h0000_0001);
    wr(`DPDC_OFF_CMD, 32'h0000_0001);
    repeat (200) @(posedge pclk);
    rdc(`DPDC_OFF_STAT, 32'h0000_0004);
    poll(32'h0000_0001);
    wr(`DPDC_OFF_STAT, 32'h0000_0001);
    wr(`DPDC_OFF_PRE0, 32'h0000_0001);
    wr(`DPDC_OFF_CNT0, 32'h0000_0000);
    wr(`DPDC_OFF_CMD, 32'h0000_0001);
    repeat (900) @(posedge pclk);
    rdc(`DPDC_OFF_STAT, 32'h0000_0004);
    poll(32'h0000_0001);
    wr(`DPDC_OFF_STAT, 32'h0000_0001);
  endtask
  task t_mod;
    wr(`DPDC_OFF_CTRL, 32'h0000_0002);
    wr(`DPDC_OFF_PRE1, 32'h0000_0001);
    wr(`DPDC_OFF_CNT1, 32'h0000_0003);
    wr(`DPDC_OFF_CMD, 32'h0000_0008);
    poll(32'h0000_0002);
    wr(`DPDC_OFF_STAT, 32'h0000_0002);
    poll(32'h0000_000a);
    wr(`DPDC_OFF_CMD, 32'h0000_0020);
    xfer(1'b0, `DPDC_OFF_CNT1, 32'h0000_0000);
    v = rd;
    repeat (20) @(posedge pclk);
    rdc(`DPDC_OFF_CNT1, v);
    wr(`DPDC_OFF_STAT, 32'h0000_0002);
    wr(`DPDC_OFF_CMD, 32'h0000_0010);
    poll(32'h0000_0002);
  endtask
  task t_irq;
    wr(`DPDC_OFF_CMD, 32'h0000_0020);
    wr(`DPDC_OFF_MASK, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk(32'({i0, i1, irq}), 32'h0000_0003);
    wr(`DPDC_OFF_MASK, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk(32'({i0, i1, irq}), 32'h0000_0000);
    wr(`DPDC_OFF_MASK, 32'h0000_0002);
    wr(`DPDC_OFF_STAT, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk(32'({i0, i1, irq}), 32'h0000_0000);
  endtask
  task t_ext;
    wr(`DPDC_OFF_CTRL, 32'h0000_0004);
    wr(`DPDC_OFF_CMD, 32'h0000_0008);
    repeat (30) @(posedge pclk);
    rdc(`DPDC_OFF_CNT1, 32'h0000_0003);
    pm.pulse(3, 2);
    poll(32'h0000_0002);
    wr(`DPDC_OFF_CTRL, 32'h0000_000c);
    wr(`DPDC_OFF_STAT, 32'h0000_0002);
    pm.pulse(1, 1);
    poll(32'h0000_0002);
    wr(`DPDC_OFF_CTRL, 32'h0000_001c);
    wr(`DPDC_OFF_CMD, 32'h0000_0008);
    wr(`DPDC_OFF_STAT, 32'h0000_0002);
    repeat (40) @(posedge pclk);
    rdc(`DPDC_OFF_CNT1, 32'h0000_0003);
    pm.pulse(1, 60);
    poll(32'h0000_0002);
    wr(`DPDC_OFF_CTRL, 32'h0000_0014);
    wr(`DPDC_OFF_STAT, 32'h0000_0002);
    pm.pulse(1, 1);
    poll(32'h0000_0002);
    wr(`DPDC_OFF_STAT, 32'h0000_0002);
    pm.pulse(1, 1);
    repeat (40) @(posedge pclk);
    rdc(`DPDC_OFF_STAT, 32'h0000_0000);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reg;
    t_single;
    t_long;
    t_mod;
    t_irq;
    t_ext;
    stop_test;
  end
  initial begin
    #400000;
    err_total++;
    stop_test;
  end
endmodule // dual_prescaled_down_counter_tb
